// ===== verilog/ufc_pkg.sv
// shared constants and types for the uart fifo control block
package ufc_pkg;

	// layout of the fifo setup control byte, msb first
	typedef struct packed {
		logic [1:0] rx_trig;  // receive threshold select
		logic [1:0] tx_trig;  // transmit threshold select
		logic       dma_sel;  // dma signalling mode
		logic       tx_rst;   // flush transmit queue
		logic       rx_rst;   // flush receive queue
		logic       en;       // enable both queues
	} ufc_setup_s;

	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam int         ENH_BIT     = 4;  // enable bit in feature reg
	localparam int         LVL_W       = 7;

	// receive thresholds in characters for codes 3..0
	localparam logic [3:0][LVL_W-1:0] RX_LVL = {
		7'h3c, 7'h38, 7'h10, 7'h08};
	// transmit thresholds in free spaces for codes 3..0
	localparam logic [3:0][LVL_W-1:0] TX_LVL = {
		7'h38, 7'h20, 7'h10, 7'h08};
	localparam logic [1:0] TX_TRIG_DEF = 2'h0;

endpackage : ufc_pkg

// ===== verilog/ufc_fifo_control.sv
// fifo queue and fifo setup control logic for one uart channel
`timescale 1ns/1ps

// queue with flush, one-entry mode and optional overwrite of the unread head entry
module ufc_fifo #(
	parameter int W  = 8,
	parameter int D  = 64,
	parameter int AW = $clog2(D),
	parameter int CW = $clog2(D + 1)
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          flush,
	input  wire logic          single,
	input  wire logic          overwrite,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data,
	output logic [CW-1:0]      count
);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic          full;
	logic          push;
	logic          pop;
	logic          over;

	// one entry only while single, otherwise full depth
	assign full      = single ? (count != '0) : (count == CW'(D));
	assign in_ready  = !full || (single && overwrite);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready && !flush;
	assign pop       = out_valid && out_ready && !flush;
	assign over      = push && full && !pop;

	// storage, an overwrite replaces the unread head entry
	always_ff @(posedge clk) begin
		if (push) begin
			mem[over ? rd_ptr : wr_ptr] <= in_data;
		end
	end

	// pointers and count, flush empties the queue in one edge
	// a push in the flush cycle is dropped so the queue starts truly empty
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push && !over) begin
				wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + CW'(push && !over) - CW'(pop);
		end
	end

endmodule : ufc_fifo

// Functional notes
// [R1] receive threshold code 00..11 selects 8, 16, 56 or 60 characters
// [R2] transmit threshold code 00..11 selects 8, 16, 32 or 56 free spaces
// [R3] transmit threshold field changes and applies only with enhanced enable
// [R4] setup bit 3 selects dma mode 0 or dma mode 1
// [R5] setup bit 2 flushes the transmit queue, shifter untouched
// [R6] setup bit 1 flushes the receive queue, shifter untouched
// [R7] each flush bit clears itself once its flush has completed
// [R8] setup bit 0 enables or disables both queues together
// [R9] after reset queues are disabled and both flush bits are zero
// [R10] setup register is write only, host keeps its own copy
// [R11] enhanced enable is feature bit 4, gates enhanced fields
// [R12] with queues disabled receive keeps one entry, new overwrites old
// [R13] threshold indications rise when count or free space reach level
module ufc_fifo_control #(
	parameter int DEPTH = 64,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       setup_wr,
	input  wire logic [7:0] setup_data,
	input  wire logic       feature_wr,
	input  wire logic [7:0] feature_data,
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char,
	input  wire logic       rx_rd,
	output logic [7:0]      rx_rd_data,
	output logic            rx_rd_valid,
	output logic            rx_avail,
	input  wire logic       tx_wr,
	input  wire logic [7:0] tx_wdata,
	output logic            tx_room,
	input  wire logic       tx_pull,
	output logic [7:0]      tx_char,
	output logic            tx_char_valid,
	output logic            tx_pending,
	output logic            rx_level_hit,
	output logic            tx_level_hit,
	output logic            fifo_enabled,
	output logic            dma_mode,
	output logic            rx_flush_busy,
	output logic            tx_flush_busy
);
	ufc_pkg::ufc_setup_s setup_in;
	logic [1:0]          rx_trig;
	logic [1:0]          tx_trig;
	logic [1:0]          tx_trig_eff;
	logic                enh_en;
	logic                en_change;
	logic                rx_in_ready;
	logic                rx_out_valid;
	logic [7:0]          rx_out_data;
	logic [CW-1:0]       rx_cnt;
	logic                tx_in_ready;
	logic                tx_out_valid;
	logic [7:0]          tx_out_data;
	logic [CW-1:0]       tx_cnt;
	logic [CW-1:0]       tx_free;

	assign setup_in  = ufc_pkg::ufc_setup_s'(setup_data);
	assign en_change = setup_wr && (setup_in.en != fifo_enabled);
	// transmit threshold falls back to its default without enhanced enable
	assign tx_trig_eff = enh_en ? tx_trig : ufc_pkg::TX_TRIG_DEF; // [R3]
	assign tx_free     = CW'(DEPTH) - tx_cnt;

	// enhanced enable, written through the feature register port
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			enh_en <= 1'b0;
		end else if (feature_wr) begin
			enh_en <= feature_data[ufc_pkg::ENH_BIT]; // [R11]
		end
	end

	// write-only setup fields, no read path exists [R10]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_trig      <= ufc_pkg::SETUP_RESET[7:6]; // [R9]
			tx_trig      <= ufc_pkg::TX_TRIG_DEF;
			dma_mode     <= ufc_pkg::SETUP_RESET[3];
			fifo_enabled <= ufc_pkg::SETUP_RESET[0];   // [R9]
		end else if (setup_wr) begin
			rx_trig      <= setup_in.rx_trig; // [R1]
			dma_mode     <= setup_in.dma_sel; // [R4]
			fifo_enabled <= setup_in.en;      // [R8]
			if (enh_en) begin
				tx_trig <= setup_in.tx_trig; // [R3]
			end
		end
	end

	// flush bits: a new request sets, otherwise clear after one flush edge
	// an enable change also flushes so one-entry mode starts clean
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_flush_busy <= 1'b0; // [R9]
			tx_flush_busy <= 1'b0; // [R9]
		end else begin
			rx_flush_busy <= (setup_wr && setup_in.rx_rst) || en_change; // [R7]
			tx_flush_busy <= (setup_wr && setup_in.tx_rst) || en_change; // [R7]
		end
	end

	// receive queue, unread head entry overwritten while disabled
	ufc_fifo #(.W(8), .D(DEPTH)) rx_q (
		.clk       (ref_clk),
		.rst_n     (reset_n),
		.flush     (rx_flush_busy),  // [R6]
		.single    (!fifo_enabled),  // [R12]
		.overwrite (1'b1),           // [R12]
		.in_valid  (rx_char_valid),
		.in_ready  (rx_in_ready),
		.in_data   (rx_char),
		.out_valid (rx_out_valid),
		.out_ready (rx_rd),
		.out_data  (rx_out_data),
		.count     (rx_cnt)
	);

	// transmit queue, one entry with back-pressure while disabled
	ufc_fifo #(.W(8), .D(DEPTH)) tx_q (
		.clk       (ref_clk),
		.rst_n     (reset_n),
		.flush     (tx_flush_busy),  // [R5]
		.single    (!fifo_enabled),
		.overwrite (1'b0),
		.in_valid  (tx_wr),
		.in_ready  (tx_in_ready),
		.in_data   (tx_wdata),
		.out_valid (tx_out_valid),
		.out_ready (tx_pull),
		.out_data  (tx_out_data),
		.count     (tx_cnt)
	);

	// registered read answer to the host
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_rd_data  <= 8'h00;
			rx_rd_valid <= 1'b0;
		end else begin
			rx_rd_valid <= rx_rd && rx_out_valid && !rx_flush_busy;
			if (rx_rd && rx_out_valid) begin
				rx_rd_data <= rx_out_data;
			end
		end
	end

	// registered character hand-off to the transmit shifter
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_char       <= 8'h00;
			tx_char_valid <= 1'b0;
		end else begin
			tx_char_valid <= tx_pull && tx_out_valid && !tx_flush_busy;
			if (tx_pull && tx_out_valid) begin
				tx_char <= tx_out_data;
			end
		end
	end

	// queue status and threshold indications, one cycle behind the count
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_avail     <= 1'b0;
			tx_room      <= 1'b0;
			tx_pending   <= 1'b0;
			rx_level_hit <= 1'b0;
			tx_level_hit <= 1'b0;
		end else begin
			rx_avail     <= rx_out_valid;
			tx_room      <= tx_in_ready;
			tx_pending   <= tx_out_valid;
			rx_level_hit <= fifo_enabled &&
				(rx_cnt >= CW'(ufc_pkg::RX_LVL[rx_trig]));     // [R13] [R1]
			tx_level_hit <= fifo_enabled &&
				(tx_free >= CW'(ufc_pkg::TX_LVL[tx_trig_eff])); // [R13] [R2]
		end
	end

	// checks on the control behaviour
	rx_level_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
		rx_level_hit |-> $past(rx_cnt) >= CW'(ufc_pkg::RX_LVL[$past(rx_trig)]))
		else $error("receive threshold raised below level");
	tx_level_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2]
		(fifo_enabled && tx_free >= CW'(ufc_pkg::TX_LVL[tx_trig_eff]))
		|=> tx_level_hit)
		else $error("transmit threshold missed at level");
	tx_lock_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R3]
		(setup_wr && !enh_en) |=> $stable(tx_trig))
		else $error("transmit threshold changed without enhanced enable");
	dma_sel_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R4]
		setup_wr ##1 !setup_wr [*2] |-> dma_mode == $past(setup_data[3], 2))
		else $error("dma mode does not follow setup write");
	tx_flush_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
		(setup_wr && setup_in.tx_rst) |-> ##2 tx_cnt == '0)
		else $error("transmit queue not emptied by flush");
	rx_flush_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
		(setup_wr && setup_in.rx_rst) |-> ##2 rx_cnt == '0)
		else $error("receive queue not emptied by flush");
	flush_clr_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
		(tx_flush_busy && !setup_wr) |=> !tx_flush_busy)
		else $error("transmit flush bit stuck after flush");
	// the receive flush bit must rise on request and fall after one edge
	rx_clr_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R7]
		(rx_flush_busy && !setup_wr) |=> !rx_flush_busy)
		else $error("receive flush bit stuck after flush");
	rx_set_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
		(setup_wr && setup_in.rx_rst) |=> rx_flush_busy)
		else $error("receive flush bit not raised by write");
	fifo_en_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
		setup_wr |=> fifo_enabled == $past(setup_in.en))
		else $error("enable does not follow setup write");
	one_entry_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R12]
		(!fifo_enabled && !$past(en_change)) |-> rx_cnt <= CW'(1))
		else $error("receive holds more than one entry while disabled");
	enh_bit_a : assert property (@(posedge ref_clk) disable iff (!reset_n) // [R11]
		feature_wr |=> enh_en == $past(feature_data[ufc_pkg::ENH_BIT]))
		else $error("enhanced enable does not follow feature write");

	rx_hit_c : cover property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(rx_level_hit));
	tx_hit_c : cover property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(tx_level_hit));
	flush_c : cover property (@(posedge ref_clk) disable iff (!reset_n)
		rx_flush_busy && rx_cnt != '0);
	overwrite_c : cover property (@(posedge ref_clk) disable iff (!reset_n)
		!fifo_enabled && rx_char_valid && rx_cnt == CW'(1));
	dma1_c : cover property (@(posedge ref_clk) disable iff (!reset_n)
		dma_mode && fifo_enabled);

endmodule : ufc_fifo_control

// ===== tb/ufc_host.sv
// host bus model that writes the setup and feature registers
`timescale 1ns/1ps
module ufc_host (
	input  wire logic ref_clk,
	output logic       setup_wr,
	output logic [7:0] setup_data,
	output logic       feature_wr,
	output logic [7:0] feature_data
);
	logic [7:0] setup_copy;  // host shadow, the register has no read-back

	initial begin
		setup_wr = 1'b0;
		setup_data = 8'h00;
		feature_wr = 1'b0;
		feature_data = 8'h00;
		setup_copy = 8'h00;
	end

	// one-cycle write, the shadow keeps what was sent
	task wr_setup(input logic [7:0] v);
		@(posedge ref_clk);
		#1;
		setup_copy = v;
		setup_wr = 1'b1;
		setup_data = v;
		@(posedge ref_clk);
		#1;
		setup_wr = 1'b0;
	endtask : wr_setup

	// one-cycle write of the feature register
	task wr_feature(input logic [7:0] v);
		@(posedge ref_clk);
		#1;
		feature_wr = 1'b1;
		feature_data = v;
		@(posedge ref_clk);
		#1;
		feature_wr = 1'b0;
	endtask : wr_feature
endmodule : ufc_host

// ===== tb/tb.sv
// self-checking bench for the uart fifo setup control block
`timescale 1ns/1ps
module tb;
	logic ref_clk, reset_n, rx_char_valid, rx_rd, tx_wr, tx_pull;
	logic [7:0] rx_char, tx_wdata, rx_rd_data, tx_char;
	logic [7:0] setup_data, feature_data;
	logic setup_wr, feature_wr, rx_rd_valid, rx_avail, tx_room;
	logic tx_char_valid, tx_pending, rx_level_hit, tx_level_hit;
	logic fifo_enabled, dma_mode, rx_flush_busy, tx_flush_busy;
	logic [7:0] rq[$], tq[$];
	int mismatches, total_checks, cyc;
	int rxl[4] = '{8, 16, 56, 60};
	int txl[4] = '{8, 16, 32, 56};

	ufc_host host (.ref_clk, .setup_wr, .setup_data, .feature_wr,
		.feature_data);
	ufc_fifo_control #(.DEPTH(64)) uut (.ref_clk, .reset_n, .setup_wr,
		.setup_data, .feature_wr, .feature_data, .rx_char_valid, .rx_char,
		.rx_rd, .rx_rd_data, .rx_rd_valid, .rx_avail, .tx_wr, .tx_wdata,
		.tx_room, .tx_pull, .tx_char, .tx_char_valid, .tx_pending,
		.rx_level_hit, .tx_level_hit, .fifo_enabled, .dma_mode,
		.rx_flush_busy, .tx_flush_busy);

	// 250 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : tick

	task chk(input logic [7:0] seen, input logic [7:0] want, input string m);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk

	task push_rx(input int n);
		repeat (n) begin
			rx_char_valid = 1'b1;
			rx_char = 8'($urandom);
			rq.push_back(rx_char);
			tick(1);
		end
		rx_char_valid = 1'b0;
	endtask : push_rx

	task push_tx(input int n);
		repeat (n) begin
			tx_wr = 1'b1;
			tx_wdata = 8'($urandom);
			tq.push_back(tx_wdata);
			tick(1);
		end
		tx_wr = 1'b0;
	endtask : push_tx

	// random gaps between pulls, n pulls are made in all
	task pull(input int n, input logic rx);
		int   k;
		logic b;
		k = 0;
		while (k < n) begin
			b = 1'($urandom);
			if (rx) rx_rd = b;
			else tx_pull = b;
			if (b) k++;
			tick(1);
		end
		rx_rd = 1'b0;
		tx_pull = 1'b0;
	endtask : pull

	task results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results

	// output watcher: each result takes the oldest note, plus the timeout
	always @(negedge ref_clk) begin
		if (rx_rd_valid === 1'b1) begin
			if (rq.size() == 0) chk(1'b1, 1'b0, "rx data not expected");
			else chk(rx_rd_data, rq.pop_front(), "rx data");
		end
		if (tx_char_valid === 1'b1) begin
			if (tq.size() == 0) chk(1'b1, 1'b0, "tx data not expected");
			else chk(tx_char, tq.pop_front(), "tx data");
		end
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		{rx_char_valid, rx_rd, tx_wr, tx_pull} = 4'h0;
		rx_char = 8'h00;
		tx_wdata = 8'h00;
		{mismatches, total_checks, cyc} = '0;
		void'($urandom(32'ha0a5d41c));
		repeat (10) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		chk(fifo_enabled, 1'b0, "enable after reset");
		chk({rx_flush_busy, tx_flush_busy}, 2'b00, "flush after reset");
		$display("test reset done");
		host.wr_setup(8'h07);
		chk(fifo_enabled, 1'b1, "enable");
		chk({rx_flush_busy, tx_flush_busy}, 2'b11, "flush start");
		tick(1);
		chk({rx_flush_busy, tx_flush_busy}, 2'b00, "flush end");
		host.wr_setup(8'h09);
		chk(dma_mode, 1'b1, "dma mode 1");
		host.wr_setup(8'h01);
		chk(dma_mode, 1'b0, "dma mode 0");
		$display("test setup done");
		for (int c = 0; c < 4; c++) begin
			host.wr_setup({c[1:0], 6'h03});
			tick(1);
			push_rx(rxl[c] - 1);
			tick(3);
			chk(rx_level_hit, 1'b0, "rx below level");
			push_rx(1);
			tick(3);
			chk(rx_level_hit, 1'b1, "rx at level");
			pull(rxl[c], 1'b1);
			tick(3);
			chk(rx_avail, 1'b0, "rx drained");
		end
		push_rx(3);
		tick(3);
		host.wr_setup(8'h03);
		rq.delete();
		tick(3);
		chk(rx_avail, 1'b0, "rx flushed");
		$display("test rx done");
		host.wr_setup(8'h35);
		tick(1);
		push_tx(9);
		tick(3);
		chk(tx_level_hit, 1'b1, "tx code ignored");
		pull(9, 1'b0);
		tick(3);
		host.wr_feature(8'($urandom) | 8'h10);
		for (int c = 0; c < 4; c++) begin
			host.wr_setup({2'($urandom), c[1:0], 1'($urandom), 3'h5});
			tick(1);
			push_tx(64 - txl[c]);
			tick(3);
			chk(tx_level_hit, 1'b1, "tx space at level");
			push_tx(1);
			tick(3);
			chk(tx_level_hit, 1'b0, "tx space below level");
			host.wr_setup(8'h05);
			tq.delete();
			tick(3);
			chk(tx_pending, 1'b0, "tx flushed");
		end
		$display("test tx done");
		host.wr_setup(8'h00);
		tick(1);
		chk(fifo_enabled, 1'b0, "disable");
		push_rx(2);
		void'(rq.pop_front());
		tick(3);
		// second read must find the single entry gone
		pull(2, 1'b1);
		tick(3);
		push_tx(1);
		tick(2);
		chk(tx_room, 1'b0, "tx room single entry");
		pull(1, 1'b0);
		tick(3);
		chk(tx_room, 1'b1, "tx room after pull");
		chk(8'(rq.size() + tq.size()), 8'h00, "results missing");
		$display("test single entry done");
		results();
	end
endmodule : tb
